// >>> hdl/typec_port_ctrl_regs.sv
// register bank with i2c slave front end for the cable-port role controller
// assumes state and event inputs come from logic on CLK; pins pass two flip-flops
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module typec_port_ctrl_regs #(
  parameter logic [3:0] VERSION_CODE = 4'h5, // arbitrary value
  parameter logic [3:0] REVISION_CODE = 4'h3 // arbitrary value
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // i2c pins, open drain
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // address strap
  input wire logic ADDR_SELECT_PIN,
  // interrupt pin, open drain
  output logic INT_OUT,
  output logic INT_OE_N,
  // port state machine side
  input wire port_regs_pkg::port_state_t PORT_STATE,
  input wire port_regs_pkg::port_event_t PORT_EVENT,
  output logic [5:0] ROLE_CONFIG,
  output logic [1:0] TOGGLE_TIMING,
  output logic [31:0] SINK_DWELL_CYCLES,
  output logic [31:0] SOURCE_DWELL_CYCLES,
  output logic [1:0] PULLUP_CURRENT_LEVEL,
  output logic [8:0] PULLUP_MICROAMPS,
  output port_regs_pkg::force_t FORCE_REQUEST,
  output logic LOGIC_RESET
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] scl_sync, sda_sync, sel_sync;
  logic scl_prev, sda_prev;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sel_sync <= 2'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], SCL_IN};
      sda_sync <= {sda_sync[0], SDA_IN};
      sel_sync <= {sel_sync[0], ADDR_SELECT_PIN};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire scl_rise = scl && !scl_prev;
  wire scl_fall = !scl && scl_prev;
  wire start_seen = scl && scl_prev && sda_prev && !sda;
  wire stop_seen = scl && scl_prev && !sda_prev && sda;

  ////////////////////////////////////////////////////////////////////////////
  // i2c byte engine
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RECV = 5'h02,
    S_ACK = 5'h04,
    S_SEND = 5'h08,
    S_RACK = 5'h10
  } bus_state_t;

  bus_state_t state;
  logic [7:0] shift;
  logic [2:0] bit_count;
  logic [1:0] byte_index; // 0 address, 1 pointer, 2 data
  logic reading;
  logic [7:0] pointer;
  logic ack_drive;

  wire [7:0] own_address = {port_regs_pkg::SLAVE_HIGH, sel_sync[1], port_regs_pkg::SLAVE_LOW, 1'b0};
  wire [7:0] rx_byte = {shift[6:0], sda};
  wire byte_done = scl_rise && (state == S_RECV) && (bit_count == 3'h7);
  wire addr_hit = (rx_byte[7:1] == own_address[7:1]);
  wire write_strobe = byte_done && (byte_index == 2'h2);
  wire pointer_strobe = byte_done && (byte_index == 2'h1);
  // fetch at the fall that ends the address ack or the master's ack
  wire read_fetch = scl_fall && reading && ((state == S_ACK && ack_drive) || state == S_RACK);
  wire accept = (byte_index != 2'h0) || addr_hit;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= S_IDLE;
      shift <= 8'h00;
      bit_count <= 3'h0;
      byte_index <= 2'h0;
      reading <= 1'b0;
      ack_drive <= 1'b0;
    end else if (start_seen) begin
      state <= S_RECV;
      bit_count <= 3'h0;
      byte_index <= 2'h0;
      reading <= 1'b0;
      ack_drive <= 1'b0;
    end else if (stop_seen) begin
      state <= S_IDLE;
      ack_drive <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: ack_drive <= 1'b0;
        S_RECV: if (scl_rise) begin
          shift <= rx_byte;
          bit_count <= bit_count + 3'h1;
        end
        // first fall opens the ack slot, the second one ends it
        S_ACK: if (scl_fall) begin
          ack_drive <= !ack_drive;
          bit_count <= 3'h0;
          if (ack_drive) state <= reading ? S_SEND : S_RECV;
        end
        S_SEND: if (scl_fall) begin
          bit_count <= bit_count + 3'h1;
          if (bit_count == 3'h7) state <= S_RACK;
        end
        // master nack on the rise ends the read, ack sends on from the fall
        S_RACK: if (scl_rise && sda) begin
          state <= S_IDLE;
        end else if (scl_fall) begin
          bit_count <= 3'h0;
          state <= S_SEND;
        end
      endcase
      // end of received byte: move to acknowledge slot if accepted, else back to idle
      if (byte_done) begin
        if (accept) begin
          state <= S_ACK;
          if (byte_index == 2'h0) reading <= rx_byte[0];
          if (byte_index != 2'h2) byte_index <= byte_index + 2'h1;
        end else begin
          state <= S_IDLE;
        end
      end
    end
  end

  // read shift register loaded at each byte start, pointer advances
  logic [7:0] tx;
  wire [7:0] read_value;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx <= 8'hff;
      pointer <= 8'h00;
    end else if (pointer_strobe) begin
      pointer <= rx_byte;
    end else if (write_strobe) begin
      pointer <= pointer + 8'h01;
    end else if (read_fetch) begin
      tx <= read_value;
      pointer <= pointer + 8'h01;
    end else if (state == S_SEND && scl_fall) begin
      tx <= {tx[6:0], 1'b1};
    end
  end

  // sda drives low for ack or a zero data bit
  wire sda_low = ack_drive || (state == S_SEND && !tx[7]);
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = !sda_low;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [5:0] role;
  logic [7:0] control;
  logic [3:0] forced;
  logic [3:0] mask;
  logic [3:0] flags;
  logic soft_reset;

  wire wr_role = write_strobe && pointer == port_regs_pkg::ADDR_ROLE;
  wire wr_control = write_strobe && pointer == port_regs_pkg::ADDR_CONTROL;
  wire wr_forced = write_strobe && pointer == port_regs_pkg::ADDR_FORCED;
  wire wr_reset = write_strobe && pointer == port_regs_pkg::ADDR_SOFT_RESET;
  wire wr_mask = write_strobe && pointer == port_regs_pkg::ADDR_MASK;
  wire rd_flags = read_fetch && pointer == port_regs_pkg::ADDR_FLAGS;

  // keep only the highest priority bit, register layout
  function automatic logic [3:0] pick(input logic [3:0] bits);
    int pos;
    pos = -1;
    if (bits[port_regs_pkg::FORCE_SINK_BIT]) pos = port_regs_pkg::FORCE_SINK_BIT;
    if (bits[port_regs_pkg::FORCE_SOURCE_BIT]) pos = port_regs_pkg::FORCE_SOURCE_BIT;
    if (bits[port_regs_pkg::FORCE_RECOVERY_BIT]) pos = port_regs_pkg::FORCE_RECOVERY_BIT;
    if (bits[port_regs_pkg::FORCE_DISABLED_BIT]) pos = port_regs_pkg::FORCE_DISABLED_BIT;
    return (pos < 0) ? 4'h0 : (4'h1 << pos);
  endfunction

  // events set flags; set wins over read-clear
  wire [3:0] event_bits = PORT_EVENT;
  wire [3:0] next_flags = (rd_flags ? 4'h0 : flags) | event_bits;
  // only the disabled bit stays after the forced move
  wire [3:0] next_forced = forced & (4'h1 << port_regs_pkg::FORCE_DISABLED_BIT);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      role <= port_regs_pkg::ROLE_RESET;
      control <= port_regs_pkg::CONTROL_RESET;
      forced <= 4'h0;
      mask <= port_regs_pkg::MASK_RESET;
      flags <= 4'h0;
      soft_reset <= 1'b0;
    end else if (soft_reset) begin
      // software reset back to reset values
      role <= port_regs_pkg::ROLE_RESET;
      control <= port_regs_pkg::CONTROL_RESET;
      forced <= 4'h0;
      mask <= port_regs_pkg::MASK_RESET;
      flags <= 4'h0;
      soft_reset <= 1'b0;
    end else begin
      if (wr_role) role <= rx_byte[5:0];
      if (wr_control) control <= {2'h0, rx_byte[5:4], 1'b0, rx_byte[2:0]};
      // forced state written, disabled held until host clears
      if (wr_forced) begin
        forced <= pick(rx_byte[3:0]);
      end else begin
        forced <= next_forced;
      end
      if (wr_mask) mask <= rx_byte[3:0];
      flags <= next_flags;
      soft_reset <= wr_reset && rx_byte[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  // identity, status, partner kind
  wire [7:0] status_value = {2'h0, PORT_STATE.plug_orientation, PORT_STATE.bus_power_valid,
                             PORT_STATE.advertised_current_level, PORT_STATE.attached};
  wire [7:0] partner_value = {3'h0, PORT_STATE.sink_seen, PORT_STATE.source_seen, 1'b0,
                              PORT_STATE.debug_accessory_seen, PORT_STATE.audio_accessory_seen};
  assign read_value =
    (pointer == port_regs_pkg::ADDR_IDENTITY) ? {VERSION_CODE, REVISION_CODE} :
    (pointer == port_regs_pkg::ADDR_ROLE) ? {2'h0, role} :
    (pointer == port_regs_pkg::ADDR_CONTROL) ? control :
    (pointer == port_regs_pkg::ADDR_FORCED) ? {4'h0, forced} :
    (pointer == port_regs_pkg::ADDR_MASK) ? {4'h0, mask} :
    (pointer == port_regs_pkg::ADDR_STATUS) ? status_value :
    (pointer == port_regs_pkg::ADDR_PARTNER) ? partner_value :
    (pointer == port_regs_pkg::ADDR_FLAGS) ? {4'h0, flags} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the port logic
  wire [1:0] toggle_code = control[port_regs_pkg::TOGGLE_LSB +: 2];
  wire [1:0] pullup_code = control[port_regs_pkg::PULLUP_LSB +: 2];
  assign TOGGLE_TIMING = toggle_code;
  assign SINK_DWELL_CYCLES = 32'(port_regs_pkg::SINK_MS[toggle_code] * port_regs_pkg::CLK_KHZ);
  assign SOURCE_DWELL_CYCLES = 32'(port_regs_pkg::SOURCE_MS[toggle_code] * port_regs_pkg::CLK_KHZ);
  assign PULLUP_CURRENT_LEVEL = pullup_code;
  assign PULLUP_MICROAMPS = 9'(port_regs_pkg::PULLUP_UA[pullup_code]);
  assign ROLE_CONFIG = role;
  // forced bits mapped onto the request codes
  assign FORCE_REQUEST =
    forced[port_regs_pkg::FORCE_DISABLED_BIT] ? port_regs_pkg::FORCE_DISABLED :
    forced[port_regs_pkg::FORCE_RECOVERY_BIT] ? port_regs_pkg::FORCE_RECOVERY :
    forced[port_regs_pkg::FORCE_SOURCE_BIT] ? port_regs_pkg::FORCE_SOURCE :
    forced[port_regs_pkg::FORCE_SINK_BIT] ? port_regs_pkg::FORCE_SINK :
    port_regs_pkg::FORCE_NONE;
  assign LOGIC_RESET = soft_reset;

  // interrupt pin low on an unmasked flag
  wire irq = |(flags & ~mask) && !control[port_regs_pkg::GLOBAL_MASK_BIT];
  assign INT_OUT = 1'b0;
  assign INT_OE_N = !irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_global_mask: assert property (@(posedge CLK) disable iff (!RST_N)
    control[0] |-> INT_OE_N) else $error("interrupt not masked globally");
  chk_flag_sets: assert property (@(posedge CLK) disable iff (!RST_N || soft_reset)
    PORT_EVENT.connection |=> flags[0]) else $error("attach flag lost");
  chk_int_drive: assert property (@(posedge CLK) disable iff (!RST_N)
    (flags[1] && !mask[1] && !control[0]) |-> !INT_OE_N) else $error("interrupt not driven");
  chk_force_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    (forced[2] && !wr_forced) |=> !forced[2]) else $error("forced bit stuck");
  chk_disabled_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    (forced[1] && !wr_forced && !soft_reset) |=> forced[1]) else $error("disabled released");
  chk_force_onehot: assert property (@(posedge CLK) disable iff (!RST_N)
    $onehot0(forced)) else $error("several forced bits");
  chk_soft_reset: assert property (@(posedge CLK) disable iff (!RST_N)
    soft_reset |=> control == 8'h03 && role == 6'h04) else $error("soft reset incomplete");
  chk_role_write: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_role && !soft_reset) |=> role == $past(rx_byte[5:0])) else $error("role not written");
  chk_ident: assert property (@(posedge CLK) disable iff (!RST_N)
    pointer == 8'h01 |-> read_value == {VERSION_CODE, REVISION_CODE}) else $error("bad id");
  cov_write: cover property (@(posedge CLK) wr_control);
  cov_irq: cover property (@(posedge CLK) !INT_OE_N);
  cov_read_flags: cover property (@(posedge CLK) rd_flags);

endmodule // typec_port_ctrl_regs

`default_nettype wire

// >>> hdl/port_regs_pkg.sv
// register map constants and field layouts for the cable-port role controller
// assumes a single 200 MHz clock domain and an i2c slave front end in the same module
package port_regs_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_IDENTITY = 8'h01;
  localparam logic [7:0] ADDR_ROLE = 8'h02;
  localparam logic [7:0] ADDR_CONTROL = 8'h03;
  localparam logic [7:0] ADDR_FORCED = 8'h04;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h05;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h11;
  localparam logic [7:0] ADDR_PARTNER = 8'h12;
  localparam logic [7:0] ADDR_FLAGS = 8'h13;

  // slave address pattern: bits 7:4 and 2:1, bit 3 from the select pin
  localparam logic [3:0] SLAVE_HIGH = 4'h4;
  localparam logic [1:0] SLAVE_LOW = 2'h1;

  // reset values
  localparam logic [5:0] ROLE_RESET = 6'h04;
  localparam logic [7:0] CONTROL_RESET = 8'h03;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // field positions in control
  localparam int TOGGLE_LSB = 4;
  localparam int PULLUP_LSB = 1;
  localparam int GLOBAL_MASK_BIT = 0;

  // forced-state bit positions
  localparam int FORCE_SINK_BIT = 3;
  localparam int FORCE_SOURCE_BIT = 2;
  localparam int FORCE_DISABLED_BIT = 1;
  localparam int FORCE_RECOVERY_BIT = 0;

  // dwell times in ms per toggle code, sink then source
  localparam int SINK_MS [4] = '{35, 30, 25, 20};
  localparam int SOURCE_MS [4] = '{15, 20, 25, 30};
  localparam int CLK_KHZ = 200000;

  // pull-up current in microamps per code
  localparam int PULLUP_UA [4] = '{0, 80, 180, 330};

  // port state requests
  typedef enum logic [3:0] {
    FORCE_NONE = 4'h0,
    FORCE_SINK = 4'h1,
    FORCE_SOURCE = 4'h2,
    FORCE_RECOVERY = 4'h4,
    FORCE_DISABLED = 4'h8
  } force_t;

  // attach state reported by the port state machine
  typedef struct packed {
    logic [1:0] plug_orientation;
    logic bus_power_valid;
    logic [1:0] advertised_current_level;
    logic attached;
    logic sink_seen;
    logic source_seen;
    logic debug_accessory_seen;
    logic audio_accessory_seen;
  } port_state_t;

  // events from the port state machine, one-cycle pulses
  typedef struct packed {
    logic accessory_change;
    logic level_change;
    logic removal;
    logic connection;
  } port_event_t;

endpackage : port_regs_pkg

// >>> tb/i2c_host_model.sv
// i2c bus master standing in for the host processor
// assumes a pulled-up data line that the device pulls low through its enable
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // pacing clock
  input wire logic clk,
  // device side of the data line
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // bus lines
  output logic scl,
  output wire logic sda
);
  logic sda_drv;
  logic [7:0] junk;
  logic nack;

  // wired-and of both drivers with the pull-up
  assign sda = sda_drv & (sda_oe_n ? 1'b1 : sda_out);

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // quarter bit time, changes land off the rising edge
  task automatic q();
    repeat (5) @(negedge clk);
  endtask

  // start or repeated start
  task automatic start_bit();
    sda_drv = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask

  task automatic stop_bit();
    sda_drv = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b1;
    q();
  endtask

  // drive one bit, sample the line mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask

  // msb first byte, then the acknowledge slot
  task automatic byte_io(input logic [7:0] v, input logic a, output logic [7:0] r,
                         output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r[i]);
    end
    bit_io(a, ack_n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // slave address byte
  function automatic logic [7:0] addr_byte(input logic sel, input logic rd);
    return {4'h4, sel, 2'h1, rd};
  endfunction

  task automatic write_reg(input logic sel, input logic [7:0] a, input logic [7:0] d,
                           output logic ack_n);
    start_bit();
    byte_io(addr_byte(sel, 1'b0), 1'b1, junk, ack_n);
    byte_io(a, 1'b1, junk, nack);
    byte_io(d, 1'b1, junk, nack);
    stop_bit();
  endtask

  // pointer write, repeated start, one byte read with no acknowledge
  task automatic read_reg(input logic sel, input logic [7:0] a, output logic [7:0] d,
                          output logic ack_n);
    start_bit();
    byte_io(addr_byte(sel, 1'b0), 1'b1, junk, ack_n);
    byte_io(a, 1'b1, junk, nack);
    start_bit();
    byte_io(addr_byte(sel, 1'b1), 1'b1, junk, nack);
    byte_io(8'hff, 1'b1, d, nack);
    stop_bit();
  endtask
endmodule // i2c_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the port controller register bank
// assumes the host model paces the bus from the bench clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [3:0] VER = 4'h6; // arbitrary value
  localparam logic [3:0] REV = 4'h9; // arbitrary value
  logic clk, rst_n, scl, sel, ack_n, sda_out, sda_oe_n, int_out, int_oe_n, logic_reset;
  logic reset_seen;
  wire logic sda;
  port_regs_pkg::port_state_t port_state;
  port_regs_pkg::port_event_t port_event;
  port_regs_pkg::force_t force_request, last_force;
  logic [5:0] role_config;
  logic [1:0] toggle_timing, pullup_level;
  logic [31:0] sink_cycles, source_cycles;
  logic [8:0] pullup_ua;
  logic [7:0] rd_val;
  int n_mismatch, samples_checked, cycles;
  int sink_ms[4] = '{35, 30, 25, 20};
  int source_ms[4] = '{15, 20, 25, 30};
  int ua[4] = '{0, 80, 180, 330};
  logic [7:0] raddr[6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h13};
  logic [7:0] rval[6] = '{{VER, REV}, 8'h04, 8'h03, 8'h00, 8'h00, 8'h00};
  logic [7:0] fwr[4] = '{8'h0f, 8'h0d, 8'h0c, 8'h08};
  logic [7:0] frd[4] = '{8'h02, 8'h00, 8'h00, 8'h00};
  port_regs_pkg::force_t fexp[4] = '{port_regs_pkg::FORCE_DISABLED,
    port_regs_pkg::FORCE_RECOVERY, port_regs_pkg::FORCE_SOURCE, port_regs_pkg::FORCE_SINK};

  typec_port_ctrl_regs #(.VERSION_CODE(VER), .REVISION_CODE(REV)) i_dut (
    .CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n), .ADDR_SELECT_PIN(sel), .INT_OUT(int_out), .INT_OE_N(int_oe_n),
    .PORT_STATE(port_state), .PORT_EVENT(port_event), .ROLE_CONFIG(role_config),
    .TOGGLE_TIMING(toggle_timing), .SINK_DWELL_CYCLES(sink_cycles),
    .SOURCE_DWELL_CYCLES(source_cycles), .PULLUP_CURRENT_LEVEL(pullup_level),
    .PULLUP_MICROAMPS(pullup_ua), .FORCE_REQUEST(force_request), .LOGIC_RESET(logic_reset));

  i2c_host_model i_host (.clk(clk), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl(scl),
    .sda(sda));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // catch one-cycle pulses
  always @(posedge clk) begin
    if (force_request !== port_regs_pkg::FORCE_NONE) last_force <= force_request;
    if (logic_reset === 1'b1) reset_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_reg(sel, a, d, ack_n);
    check(ack_n, 0, "address ack");
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_host.read_reg(sel, a, rd_val, ack_n);
    check(rd_val, exp, "read");
  endtask

  task automatic pulse(input int i);
    @(negedge clk);
    port_event = port_regs_pkg::port_event_t'(4'h1 << i);
    @(negedge clk);
    port_event = '0;
    repeat (2) @(negedge clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    sel = 1'b0;
    port_state = '0;
    port_event = '0;
    reset_seen = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 6; i++) rd(raddr[i], rval[i]);
    check(pullup_level, 2'h1, "pullup code");
    check(pullup_ua, 9'd80, "pullup ua");
    $display("test reset values done");
    i_host.write_reg(1'b1, 8'h02, 8'h01, ack_n);
    check(ack_n, 1'b1, "foreign address");
    sel = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      wr(8'h02, 8'h01 << i);
      rd(8'h02, 8'h01 << i);
      check(role_config, 6'h01 << i, "role out");
    end
    wr(8'h01, 8'hff);
    rd(8'h01, {VER, REV});
    $display("test address and role done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h03, {2'h0, 2'(c), 1'b0, 2'(c), 1'b0});
      rd(8'h03, {2'h0, 2'(c), 1'b0, 2'(c), 1'b0});
      check(toggle_timing, c, "toggle");
      check(sink_cycles, sink_ms[c] * 200000, "sink dwell");
      check(source_cycles, source_ms[c] * 200000, "source dwell");
      check(pullup_level, c, "pullup code");
      check(pullup_ua, ua[c], "pullup ua");
      port_state = '{plug_orientation: 2'(c), bus_power_valid: c[0],
        advertised_current_level: 2'(c), attached: c[1], sink_seen: c[0],
        source_seen: c[1], debug_accessory_seen: c[0], audio_accessory_seen: c[1]};
      i_host.read_reg(sel, 8'h11, rd_val, ack_n);
      check(rd_val & 8'h3f, {2'h0, 2'(c), c[0], 2'(c), c[1]}, "status");
      i_host.read_reg(sel, 8'h12, rd_val, ack_n);
      check(rd_val & 8'h1b, {3'h0, c[0], c[1], 1'b0, c[0], c[1]}, "kind");
    end
    $display("test control and status done");
    wr(8'h03, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(8'h10, 8'h01 << i);
      pulse(i);
      check(int_oe_n, 1'b1, "masked pin");
      i_host.read_reg(sel, 8'h13, rd_val, ack_n);
      check(rd_val, 8'h01 << i, "masked flag");
      wr(8'h10, 8'h00);
      pulse(i);
      check(int_oe_n, 1'b0, "pin driven");
      check(int_out, 1'b0, "pin level");
      rd(8'h13, 8'h01 << i);
      check(int_oe_n, 1'b1, "pin released");
    end
    wr(8'h03, 8'h03);
    pulse(0);
    check(int_oe_n, 1'b1, "global mask");
    rd(8'h13, 8'h01);
    $display("test interrupts done");
    for (int i = 0; i < 4; i++) begin
      last_force = port_regs_pkg::FORCE_NONE;
      wr(8'h04, fwr[i]);
      check(last_force, fexp[i], "forced state");
      rd(8'h04, frd[i]);
      if (i == 0) wr(8'h04, 8'h00);
      check(force_request, port_regs_pkg::FORCE_NONE, "force idle");
    end
    $display("test forced state done");
    wr(8'h02, 8'h01);
    wr(8'h10, 8'h0f);
    wr(8'h05, 8'h01);
    check(reset_seen, 1'b1, "logic reset");
    rd(8'h02, 8'h04);
    rd(8'h10, 8'h00);
    rd(8'h03, 8'h03);
    rd(8'h05, 8'h00);
    $display("test soft reset done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
